/* design/rpg_params.svh */
// Offsets, field positions, reset values and timing of the guard block
`ifndef RPG_PARAMS_SVH
`define RPG_PARAMS_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define RPG_OFS_SEL 8'h00
`define RPG_OFS_CMD 8'h04
`define RPG_OFS_STAT 8'h08
`define RPG_OFS_ACC 8'h0C
`define RPG_OFS_MODE 8'h10

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define RPG_SEL_F 4:0
`define RPG_CMD_CLR 0
`define RPG_MD_OPM 1:0
`define RPG_MD_RS485 2
`define RPG_MD_SRC 4:3
`define RPG_MD_COAST 5
`define RPG_ST_TRIP 0
`define RPG_ST_LOSS 1
`define RPG_ST_PS 2
`define RPG_ST_OUT 3
`define RPG_ST_DECEL 4
`define RPG_ST_SEEN 5
`define RPG_ST_PSFP 6
`define RPG_ACC_TH 15:0
`define RPG_ACC_BR 31:16

// ---------------------------------------------------------------
// Reset values and bus answers
// ---------------------------------------------------------------
`define RPG_SEL_RST 5'h0E
`define RPG_RESP_OK 2'h0
`define RPG_RESP_ERR 2'h2

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define RPG_CLK_KHZ 10000
`define RPG_LOSS_MS 1000
`define RPG_LOSS_CYC (`RPG_LOSS_MS * `RPG_CLK_KHZ)

`endif

/* design/rpg_pkg.sv */
// Types of the reset, panel-loss and panel-stop guard
package rpg_pkg;

  typedef enum logic [1:0] {
    RPG_IDLE = 2'b00,
    RPG_RUN = 2'b01,
    RPG_DECEL = 2'b10,
    RPG_TRIP = 2'b11
  } rpg_motion_e;

  typedef enum logic [1:0] {
    RPG_PANEL = 2'b00,
    RPG_EXTERNAL = 2'b01,
    RPG_COMM = 2'b10
  } rpg_mode_e;

  typedef enum logic [1:0] {
    RPG_SRC_AUTO = 2'b00,
    RPG_SRC_UNIT = 2'b01,
    RPG_SRC_FRONT = 2'b10
  } rpg_src_e;

  typedef struct packed {
    rpg_motion_e mot;
    logic outen;
    logic decel;
    logic [4:0] sel;
    rpg_mode_e opm;
    logic rs485;
    rpg_src_e src;
    logic coast;
    logic seen;
    logic [23:0] lcnt;
    logic loss;
    logic ps;
    logic ps_fp;
    logic trip;
    logic start_q;
    logic [15:0] therm;
    logic [15:0] brake;
    logic awrdy;
    logic wrdy;
    logic awgot;
    logic wgot;
    logic [7:0] awa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic bvalid;
    logic [1:0] bresp;
    logic arrdy;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rpg_state_s;

endpackage

/* design/rpg_guard.sv */
// Reset acceptance, panel-loss trip and panel-stop guard with AXI4-Lite
`timescale 1ns/1ns
`include "rpg_params.svh"

// How it works
// [R1] Selector takes 0-3, 14-17; starts at 14
// [R2] Selector writable in any operating state
// [R3] Parameter clear leaves selector untouched
// [R4] Odd codes: pin/comm reset only when tripped
// [R5] Accepted reset while running: output off, coast
// [R6] Every reset clears thermal and brake accumulators
// [R7] Panel reset key acts only while tripped
// [R8] Codes 2,3,16,17: panel gone over 1s trips
// [R9] Codes 0,1,14,15: panel loss keeps running
// [R10] Panel absent since power-on is no loss
// [R11] Panel jog still decelerates on panel loss
// [R12] RS-485 via connector disables loss detection
// [R13] Codes 0-3: no latch, stop only panel mode
// [R14] Codes 14-17: stop key works in all modes
// [R15] Latched stop cleared only by issuing unit
// [R16] Power reset or terminal reset clears latch
// [R17] Operator releases start, clears, restarts
// [R18] Panel stop decelerates even with coast setting
// [R19] Stop from unselected unit in panel mode latches
// [R20] Front stop during RS-485 panel mode latches
// [R21] Source 9999: detachable unit beats front panel
// [R22] Trip holds until accepted reset or power-up
module rpg_guard #(
  parameter int LOSS_CYCLES = `RPG_LOSS_CYC
) (
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  input wire logic [7:0] AXI_AWADDR_I,
  input wire logic AXI_AWVALID_I,
  output logic AXI_AWREADY_O,
  input wire logic [31:0] AXI_WDATA_I,
  input wire logic [3:0] AXI_WSTRB_I,
  input wire logic AXI_WVALID_I,
  output logic AXI_WREADY_O,
  output logic [1:0] AXI_BRESP_O,
  output logic AXI_BVALID_O,
  input wire logic AXI_BREADY_I,
  input wire logic [7:0] AXI_ARADDR_I,
  input wire logic AXI_ARVALID_I,
  output logic AXI_ARREADY_O,
  output logic [31:0] AXI_RDATA_O,
  output logic [1:0] AXI_RRESP_O,
  output logic AXI_RVALID_O,
  input wire logic AXI_RREADY_I,
  input wire logic EXTERNAL_RESET_INPUT_I,
  input wire logic COMM_RESET_I,
  input wire logic FORWARD_START_INPUT_I,
  input wire logic REVERSE_START_INPUT_I,
  input wire logic PANEL_RUN_I,
  input wire logic PANEL_JOG_I,
  input wire logic UNIT_PRESENT_I,
  input wire logic UNIT_STOP_KEY_I,
  input wire logic FRONT_STOP_KEY_I,
  input wire logic UNIT_RESET_KEY_I,
  input wire logic FRONT_RESET_KEY_I,
  input wire logic UNIT_STOP_CLEAR_I,
  input wire logic FRONT_STOP_CLEAR_I,
  input wire logic MOTOR_STOPPED_I,
  input wire logic FAULT_I,
  input wire logic THERMAL_INC_I,
  input wire logic BRAKE_INC_I,
  output logic OUTPUT_EN_O,
  output logic DECEL_O,
  output logic TRIPPED_O,
  output logic PANEL_LOSS_FAULT_O,
  output logic PANEL_STOP_LATCHED_O
);

  localparam logic [23:0] LOSS_LIM = LOSS_CYCLES[23:0];

  rpg_pkg::rpg_state_s q;
  rpg_pkg::rpg_state_s n;

  logic tripped;
  logic rst_pin_ok;
  logic rst_key_ok;
  logic rst_any;
  logic hi_codes;
  logic trip_sel;
  logic det_en;
  logic absent;
  logic lost;
  logic jog_lost;
  logic start;
  logic start_rise;
  logic unit_sel;
  logic front_sel;
  logic stop_hit;
  logic stop_latch;
  logic ps_clear;
  logic [31:0] stat;
  logic [31:0] acc;

  // ---------------------------------------------------------------
  // Selector code check
  // ---------------------------------------------------------------
  function automatic logic sel_legal(input logic [4:0] c);
    sel_legal = (c <= 5'h03) || ((c >= 5'h0E) && (c <= 5'h11));
  endfunction

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    n = q;
    tripped = (q.mot == rpg_pkg::RPG_TRIP);
    hi_codes = q.sel[4] | q.sel[3];
    // [R4] odd code restricts reset
    rst_pin_ok = (EXTERNAL_RESET_INPUT_I | COMM_RESET_I) &
                 (~q.sel[0] | tripped);
    // [R7] panel key only tripped
    rst_key_ok = (UNIT_RESET_KEY_I | FRONT_RESET_KEY_I) & tripped;
    rst_any = rst_pin_ok | rst_key_ok;

    // [R8] trip-on-loss codes
    trip_sel = hi_codes ? q.sel[4] : q.sel[1];
    // [R12] RS-485 disables detection
    det_en = trip_sel & ~q.rs485;
    // [R10] only after panel seen
    absent = q.seen & ~UNIT_PRESENT_I;
    lost = det_en & absent & (q.lcnt == LOSS_LIM);
    // [R11] jog stops on panel loss
    jog_lost = PANEL_JOG_I & (q.opm == rpg_pkg::RPG_PANEL) &
               absent & ~trip_sel;

    // [R21] unit wins in auto source
    unit_sel = 1'b0;
    front_sel = 1'b0;
    if (!(q.rs485 && q.opm == rpg_pkg::RPG_PANEL)) begin
      unique case (q.src)
        rpg_pkg::RPG_SRC_AUTO: begin
          unit_sel = UNIT_PRESENT_I;
          front_sel = ~UNIT_PRESENT_I;
        end
        rpg_pkg::RPG_SRC_UNIT: unit_sel = 1'b1;
        rpg_pkg::RPG_SRC_FRONT: front_sel = 1'b1;
        default: front_sel = 1'b1;
      endcase
    end

    stop_hit = 1'b0;
    stop_latch = 1'b0;
    if (hi_codes) begin
      // [R14] stop in every mode
      stop_hit = (UNIT_STOP_KEY_I & UNIT_PRESENT_I) | FRONT_STOP_KEY_I;
      // [R19] unselected unit latches
      // [R20] front stop in RS-485
      stop_latch = ((UNIT_STOP_KEY_I & UNIT_PRESENT_I & ~unit_sel) |
                    (FRONT_STOP_KEY_I & ~front_sel)) |
                   (stop_hit & (q.opm != rpg_pkg::RPG_PANEL));
    end else begin
      // [R13] panel mode only, no latch
      stop_hit = (q.opm == rpg_pkg::RPG_PANEL) &
                 ((UNIT_STOP_KEY_I & UNIT_PRESENT_I) | FRONT_STOP_KEY_I);
    end

    // [R15] clear from issuing unit
    ps_clear = q.ps & (q.ps_fp ? FRONT_STOP_CLEAR_I : UNIT_STOP_CLEAR_I);

    start = FORWARD_START_INPUT_I | REVERSE_START_INPUT_I | PANEL_RUN_I;
    start_rise = start & ~q.start_q;
    n.start_q = start;

    // ---------------------------------------------------------------
    // Panel presence and loss timer
    // ---------------------------------------------------------------
    if (UNIT_PRESENT_I) begin
      n.seen = 1'b1;
    end
    if (det_en && absent) begin
      if (q.lcnt != LOSS_LIM) begin
        n.lcnt = q.lcnt + 24'h000001;
      end
    end else begin
      n.lcnt = 24'h000000;
    end

    // ---------------------------------------------------------------
    // Panel stop latch
    // ---------------------------------------------------------------
    if (ps_clear) begin
      n.ps = 1'b0;
    end
    if (stop_latch && (!q.ps || ps_clear)) begin
      n.ps = 1'b1;
      n.ps_fp = ~(UNIT_STOP_KEY_I & UNIT_PRESENT_I);
    end

    // ---------------------------------------------------------------
    // Motion
    // ---------------------------------------------------------------
    unique case (q.mot)
      rpg_pkg::RPG_IDLE: begin
        // [R15] no restart while latched
        if (start_rise && !q.ps && !stop_hit) begin
          n.mot = rpg_pkg::RPG_RUN;
        end
      end
      rpg_pkg::RPG_RUN: begin
        // [R18] panel stop always decelerates
        if (stop_hit || jog_lost) begin
          n.mot = rpg_pkg::RPG_DECEL;
        end else if (!start) begin
          n.mot = q.coast ? rpg_pkg::RPG_IDLE : rpg_pkg::RPG_DECEL;
        end
      end
      rpg_pkg::RPG_DECEL: begin
        if (MOTOR_STOPPED_I) begin
          n.mot = rpg_pkg::RPG_IDLE;
        end
      end
      rpg_pkg::RPG_TRIP: begin
        // [R22] trip holds
        n.mot = rpg_pkg::RPG_TRIP;
      end
    endcase

    // [R9] loss trips only on trip codes
    if (lost) begin
      n.loss = 1'b1;
      n.mot = rpg_pkg::RPG_TRIP;
    end
    if (FAULT_I) begin
      n.mot = rpg_pkg::RPG_TRIP;
    end

    if (q.outen) begin
      n.therm = q.therm + {15'h0000, THERMAL_INC_I};
      n.brake = q.brake + {15'h0000, BRAKE_INC_I};
    end

    if (rst_any) begin
      // [R5] output off at once
      n.mot = rpg_pkg::RPG_IDLE;
      n.loss = 1'b0;
      n.lcnt = 24'h000000;
      // [R6] clear accumulators
      n.therm = 16'h0000;
      n.brake = 16'h0000;
      n.start_q = 1'b1;
    end
    if (rst_pin_ok) begin
      // [R16] terminal reset clears latch
      n.ps = 1'b0;
    end

    n.outen = (n.mot == rpg_pkg::RPG_RUN) || (n.mot == rpg_pkg::RPG_DECEL);
    n.decel = (n.mot == rpg_pkg::RPG_DECEL);
    n.trip = (n.mot == rpg_pkg::RPG_TRIP);

    // ---------------------------------------------------------------
    // AXI4-Lite write
    // ---------------------------------------------------------------
    if (AXI_AWVALID_I && q.awrdy) begin
      n.awrdy = 1'b0;
      n.awgot = 1'b1;
      n.awa = AXI_AWADDR_I;
    end
    if (AXI_WVALID_I && q.wrdy) begin
      n.wrdy = 1'b0;
      n.wgot = 1'b1;
      n.wd = AXI_WDATA_I;
      n.ws = AXI_WSTRB_I;
    end
    if (q.bvalid && AXI_BREADY_I) begin
      n.bvalid = 1'b0;
      n.awrdy = 1'b1;
      n.wrdy = 1'b1;
    end
    if (q.awgot && q.wgot) begin
      n.awgot = 1'b0;
      n.wgot = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `RPG_RESP_OK;
      unique case (q.awa)
        `RPG_OFS_SEL: begin
          // [R1] legal codes only
          // [R2] any operating state
          if (q.ws[0] && sel_legal(q.wd[`RPG_SEL_F])) begin
            n.sel = q.wd[`RPG_SEL_F];
          end
        end
        `RPG_OFS_MODE: begin
          if (q.ws[0]) begin
            if (q.wd[`RPG_MD_OPM] != 2'h3) begin
              n.opm = rpg_pkg::rpg_mode_e'(q.wd[`RPG_MD_OPM]);
            end
            if (q.wd[`RPG_MD_SRC] != 2'h3) begin
              n.src = rpg_pkg::rpg_src_e'(q.wd[`RPG_MD_SRC]);
            end
            n.rs485 = q.wd[`RPG_MD_RS485];
            n.coast = q.wd[`RPG_MD_COAST];
          end
        end
        `RPG_OFS_CMD: begin
          // [R3] clear keeps selector
          if (q.ws[0] && q.wd[`RPG_CMD_CLR]) begin
            n.opm = rpg_pkg::RPG_PANEL;
            n.src = rpg_pkg::RPG_SRC_AUTO;
            n.rs485 = 1'b0;
            n.coast = 1'b0;
          end
        end
        `RPG_OFS_STAT, `RPG_OFS_ACC: n.bresp = `RPG_RESP_OK;
        default: n.bresp = `RPG_RESP_ERR;
      endcase
    end

    // ---------------------------------------------------------------
    // AXI4-Lite read
    // ---------------------------------------------------------------
    stat = 32'h00000000;
    stat[`RPG_ST_TRIP] = tripped;
    stat[`RPG_ST_LOSS] = q.loss;
    stat[`RPG_ST_PS] = q.ps;
    stat[`RPG_ST_OUT] = q.outen;
    stat[`RPG_ST_DECEL] = q.decel;
    stat[`RPG_ST_SEEN] = q.seen;
    stat[`RPG_ST_PSFP] = q.ps_fp;
    acc = 32'h00000000;
    acc[`RPG_ACC_TH] = q.therm;
    acc[`RPG_ACC_BR] = q.brake;
    if (q.rvalid && AXI_RREADY_I) begin
      n.rvalid = 1'b0;
      n.arrdy = 1'b1;
    end
    if (AXI_ARVALID_I && q.arrdy) begin
      n.arrdy = 1'b0;
      n.rvalid = 1'b1;
      n.rresp = `RPG_RESP_OK;
      unique case (AXI_ARADDR_I)
        `RPG_OFS_SEL: n.rdata = {27'h0000000, q.sel};
        `RPG_OFS_CMD: n.rdata = 32'h00000000;
        `RPG_OFS_STAT: n.rdata = stat;
        `RPG_OFS_ACC: n.rdata = acc;
        `RPG_OFS_MODE: begin
          n.rdata = 32'h00000000;
          n.rdata[`RPG_MD_OPM] = q.opm;
          n.rdata[`RPG_MD_RS485] = q.rs485;
          n.rdata[`RPG_MD_SRC] = q.src;
          n.rdata[`RPG_MD_COAST] = q.coast;
        end
        default: begin
          n.rdata = 32'h00000000;
          n.rresp = `RPG_RESP_ERR;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      q <= '0;
      // [R1] initial selector 14
      q.sel <= `RPG_SEL_RST;
      q.awrdy <= 1'b1;
      q.wrdy <= 1'b1;
      q.arrdy <= 1'b1;
      q.start_q <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign AXI_AWREADY_O = q.awrdy;
  assign AXI_WREADY_O = q.wrdy;
  assign AXI_BVALID_O = q.bvalid;
  assign AXI_BRESP_O = q.bresp;
  assign AXI_ARREADY_O = q.arrdy;
  assign AXI_RVALID_O = q.rvalid;
  assign AXI_RDATA_O = q.rdata;
  assign AXI_RRESP_O = q.rresp;
  assign OUTPUT_EN_O = q.outen;
  assign DECEL_O = q.decel;
  assign TRIPPED_O = q.trip;
  assign PANEL_LOSS_FAULT_O = q.loss;
  assign PANEL_STOP_LATCHED_O = q.ps;

endmodule

/* test/rpg_guard_props.sv */
// Checker properties of the guard block
`timescale 1ns/1ns
module rpg_guard_props #(
  parameter int LOSS_CYCLES = 20
) (
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  input wire logic AXI_AWREADY_O,
  input wire logic AXI_WREADY_O,
  input wire logic [1:0] AXI_BRESP_O,
  input wire logic AXI_BVALID_O,
  input wire logic AXI_BREADY_I,
  input wire logic [31:0] AXI_RDATA_O,
  input wire logic AXI_RVALID_O,
  input wire logic AXI_RREADY_I,
  input wire logic EXTERNAL_RESET_INPUT_I,
  input wire logic COMM_RESET_I,
  input wire logic UNIT_RESET_KEY_I,
  input wire logic FRONT_RESET_KEY_I,
  input wire logic UNIT_STOP_CLEAR_I,
  input wire logic FRONT_STOP_CLEAR_I,
  input wire logic OUTPUT_EN_O,
  input wire logic DECEL_O,
  input wire logic TRIPPED_O,
  input wire logic PANEL_LOSS_FAULT_O,
  input wire logic PANEL_STOP_LATCHED_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);
  wire logic keep = !UNIT_STOP_CLEAR_I && !FRONT_STOP_CLEAR_I &&
    !EXTERNAL_RESET_INPUT_I && !COMM_RESET_I;
  wire logic no_rst = !EXTERNAL_RESET_INPUT_I && !COMM_RESET_I &&
    !UNIT_RESET_KEY_I && !FRONT_RESET_KEY_I;
  // ---------------------------------------------
  // Assertions
  // ---------------------------------------------
  a_decel_powered: assert property (DECEL_O |-> OUTPUT_EN_O)
    else $error("decel without output");
  a_trip_off: assert property (TRIPPED_O |-> !OUTPUT_EN_O)
    else $error("output on while tripped");
  a_loss_trips: assert property (PANEL_LOSS_FAULT_O |-> TRIPPED_O)
    else $error("loss fault without trip");
  a_trip_holds: assert property (TRIPPED_O && no_rst |=> TRIPPED_O)
    else $error("trip dropped without reset");
  a_latch_holds: assert property (
    PANEL_STOP_LATCHED_O && keep |=> PANEL_STOP_LATCHED_O)
    else $error("latch dropped without clear");
  a_latch_norun: assert property (
    PANEL_STOP_LATCHED_O && !OUTPUT_EN_O && keep |=> !OUTPUT_EN_O)
    else $error("run while latched");
  a_bresp_stands: assert property (
    AXI_BVALID_O && !AXI_BREADY_I |=> AXI_BVALID_O && $stable(AXI_BRESP_O))
    else $error("write answer not held");
  a_rdata_stands: assert property (
    AXI_RVALID_O && !AXI_RREADY_I |=> AXI_RVALID_O && $stable(AXI_RDATA_O))
    else $error("read answer not held");
  a_write_refused: assert property (
    AXI_BVALID_O |-> !AXI_AWREADY_O && !AXI_WREADY_O)
    else $error("write taken during answer");
  // ---------------------------------------------
  // Covers
  // ---------------------------------------------
  c_latch: cover property ($rose(PANEL_STOP_LATCHED_O));
  c_loss: cover property ($rose(PANEL_LOSS_FAULT_O));
  c_decel: cover property ($rose(DECEL_O));
endmodule
bind rpg_guard rpg_guard_props #(.LOSS_CYCLES(LOSS_CYCLES)) u_props (.*);

/* test/rpg_panel_model.sv */
// Operator panel unit and terminal pins model
`timescale 1ns/1ns
module rpg_panel_model (
  input wire logic clk_i,
  output logic [8:0] pins_o
);
  initial pins_o = 9'h000;
  task automatic set(input int i, input logic v);
    pins_o[i] <= v;
  endtask
  task automatic pulse(input int i);
    pins_o[i] <= 1'h1;
    @(posedge clk_i);
    pins_o[i] <= 1'h0;
    @(posedge clk_i);
  endtask
endmodule

/* test/tb_rpg_guard.sv */
// Testbench of the guard block
`timescale 1ns/1ns
`include "rpg_params.svh"
module tb_rpg_guard;
  localparam int P = 0, US = 1, FS = 2, UR = 3, FR = 4;
  localparam int UC = 5, FC = 6, FW = 7, RS = 8;
  logic clk, rst_n, awv, wv, bready, arv, rready, fault, inc, comm, mstop, jog;
  logic awr, wrd, bv, arr, rv, out_en, decel, trip, loss, latched;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic [8:0] pins;
  int mismatches = 0;
  int check_count = 0;
  rpg_panel_model pm (.clk_i(clk), .pins_o(pins));
  rpg_guard #(.LOSS_CYCLES(20)) dut (
    .MCLK_I(clk), .RST_N_I(rst_n),
    .AXI_AWADDR_I(awaddr), .AXI_AWVALID_I(awv), .AXI_AWREADY_O(awr),
    .AXI_WDATA_I(wdata), .AXI_WSTRB_I(4'hF), .AXI_WVALID_I(wv),
    .AXI_WREADY_O(wrd), .AXI_BRESP_O(bresp), .AXI_BVALID_O(bv),
    .AXI_BREADY_I(bready), .AXI_ARADDR_I(araddr), .AXI_ARVALID_I(arv),
    .AXI_ARREADY_O(arr), .AXI_RDATA_O(rdata), .AXI_RRESP_O(rresp),
    .AXI_RVALID_O(rv), .AXI_RREADY_I(rready),
    .EXTERNAL_RESET_INPUT_I(pins[RS]), .COMM_RESET_I(comm),
    .FORWARD_START_INPUT_I(pins[FW]), .REVERSE_START_INPUT_I(1'h0),
    .PANEL_RUN_I(1'h0), .PANEL_JOG_I(jog), .UNIT_PRESENT_I(pins[P]),
    .UNIT_STOP_KEY_I(pins[US]), .FRONT_STOP_KEY_I(pins[FS]),
    .UNIT_RESET_KEY_I(pins[UR]), .FRONT_RESET_KEY_I(pins[FR]),
    .UNIT_STOP_CLEAR_I(pins[UC]), .FRONT_STOP_CLEAR_I(pins[FC]),
    .MOTOR_STOPPED_I(mstop), .FAULT_I(fault), .THERMAL_INC_I(inc),
    .BRAKE_INC_I(inc), .OUTPUT_EN_O(out_en), .DECEL_O(decel),
    .TRIPPED_O(trip), .PANEL_LOSS_FAULT_O(loss),
    .PANEL_STOP_LATCHED_O(latched)
  );
  // ---------------------------------------------
  // Helpers
  // ---------------------------------------------
  task automatic tally_and_finish;
    if (mismatches == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic tmo;
    mismatches++;
    tally_and_finish();
  endtask
  task automatic bad(input string n, input logic [31:0] e, input logic [31:0] g);
    mismatches++;
    $display("wrong value %s exp %0h got %0h", n, e, g);
  endtask
  task automatic chk(input string n, input logic e, input logic g);
    check_count++;
    if (g !== e) bad(n, {31'h0, e}, {31'h0, g});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic axi_w(input logic [7:0] a, input logic [31:0] v);
    logic pa, pw;
    int n;
    pa = 1'h1;
    pw = 1'h1;
    awaddr <= a;
    wdata <= v;
    awv <= 1'h1;
    wv <= 1'h1;
    bready <= 1'h1;
    for (n = 0; n < 40 && (pa || pw); n++) begin
      @(posedge clk);
      if (awr === 1'h1) pa = 1'h0;
      if (wrd === 1'h1) pw = 1'h0;
      awv <= pa;
      wv <= pw;
    end
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (bv === 1'h1) break;
    end
    r = bresp;
    bready <= 1'h0;
    if (n == 40) tmo();
    @(posedge clk);
  endtask
  task automatic axi_r(input logic [7:0] a);
    int n;
    araddr <= a;
    arv <= 1'h1;
    rready <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (arr === 1'h1) break;
    end
    arv <= 1'h0;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (rv === 1'h1) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'h0;
    if (n == 40) tmo();
    @(posedge clk);
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    axi_r(a);
    check_count++;
    if (d !== e) bad(n, e, d);
  endtask
  // ---------------------------------------------
  // Scenarios
  // ---------------------------------------------
  task automatic t_regs;
    rdc("sel", `RPG_OFS_SEL, 32'h0000000E);
    axi_w(`RPG_OFS_SEL, 32'h00000005);
    rdc("sel", `RPG_OFS_SEL, 32'h0000000E);
    axi_r(8'h20);
    chk("rresp", 1'h1, r === 2'h2);
    axi_w(8'h20, 32'h00000000);
    chk("bresp", 1'h1, r === 2'h2);
    axi_w(`RPG_OFS_MODE, 32'h00000001);
    axi_w(`RPG_OFS_SEL, 32'h00000003);
    axi_w(`RPG_OFS_CMD, 32'h00000001);
    rdc("sel", `RPG_OFS_SEL, 32'h00000003);
    rdc("mode", `RPG_OFS_MODE, 32'h00000000);
    axi_w(`RPG_OFS_SEL, 32'h0000000E);
  endtask
  task automatic t_stop;
    axi_w(`RPG_OFS_MODE, 32'h00000021);
    pm.set(FW, 1'h1);
    tick(2);
    chk("out", 1'h1, out_en);
    axi_w(`RPG_OFS_SEL, 32'h00000011);
    rdc("sel", `RPG_OFS_SEL, 32'h00000011);
    axi_w(`RPG_OFS_SEL, 32'h0000000E);
    pm.pulse(FS);
    chk("decel", 1'h1, decel);
    chk("latch", 1'h1, latched);
    mstop <= 1'h1;
    tick(2);
    chk("out", 1'h0, out_en);
    mstop <= 1'h0;
    pm.set(FW, 1'h0);
    tick(2);
    pm.set(FW, 1'h1);
    tick(2);
    chk("out", 1'h0, out_en);
    pm.set(FW, 1'h0);
    pm.pulse(UC);
    chk("latch", 1'h1, latched);
    pm.pulse(FC);
    chk("latch", 1'h0, latched);
    pm.set(FW, 1'h1);
    tick(2);
    chk("out", 1'h1, out_en);
    pm.pulse(FS);
    pm.pulse(RS);
    chk("latch", 1'h0, latched);
    chk("out", 1'h0, out_en);
    pm.set(FW, 1'h0);
    axi_w(`RPG_OFS_SEL, 32'h00000000);
    pm.set(FW, 1'h1);
    tick(2);
    pm.pulse(FS);
    chk("latch", 1'h0, latched);
    chk("out", 1'h1, out_en);
    pm.set(FW, 1'h0);
    tick(2);
  endtask
  task automatic t_res;
    axi_w(`RPG_OFS_SEL, 32'h0000000F);
    pm.set(FW, 1'h1);
    tick(2);
    pm.pulse(RS);
    chk("out", 1'h1, out_en);
    inc <= 1'h1;
    tick(5);
    inc <= 1'h0;
    rdc("acc", `RPG_OFS_ACC, 32'h00050005);
    axi_w(`RPG_OFS_SEL, 32'h0000000E);
    pm.pulse(RS);
    chk("out", 1'h0, out_en);
    rdc("acc", `RPG_OFS_ACC, 32'h00000000);
    pm.set(FW, 1'h0);
    axi_w(`RPG_OFS_SEL, 32'h0000000F);
    fault <= 1'h1;
    tick(1);
    fault <= 1'h0;
    tick(6);
    chk("trip", 1'h1, trip);
    comm <= 1'h1;
    tick(1);
    comm <= 1'h0;
    tick(1);
    chk("trip", 1'h0, trip);
  endtask
  task automatic t_loss;
    axi_w(`RPG_OFS_SEL, 32'h00000010);
    tick(30);
    chk("loss", 1'h0, loss);
    pm.set(P, 1'h1);
    tick(3);
    pm.set(P, 1'h0);
    tick(30);
    chk("loss", 1'h1, loss);
    chk("trip", 1'h1, trip);
    pm.set(P, 1'h1);
    pm.pulse(FR);
    chk("trip", 1'h0, trip);
    axi_w(`RPG_OFS_MODE, 32'h00000004);
    pm.set(P, 1'h0);
    tick(30);
    chk("loss", 1'h0, loss);
    axi_w(`RPG_OFS_MODE, 32'h00000001);
    axi_w(`RPG_OFS_SEL, 32'h0000000E);
    pm.set(P, 1'h1);
    pm.set(FW, 1'h1);
    tick(3);
    pm.set(P, 1'h0);
    tick(30);
    chk("loss", 1'h0, loss);
    chk("out", 1'h1, out_en);
    pm.pulse(FR);
    chk("out", 1'h1, out_en);
  endtask
  task automatic t_jog;
    pm.set(FW, 1'h0);
    mstop <= 1'h1;
    axi_w(`RPG_OFS_MODE, 32'h00000000);
    mstop <= 1'h0;
    pm.set(P, 1'h1);
    pm.set(FW, 1'h1);
    jog <= 1'h1;
    tick(3);
    chk("out", 1'h1, out_en);
    pm.set(P, 1'h0);
    tick(2);
    chk("decel", 1'h1, decel);
    jog <= 1'h0;
    pm.set(FW, 1'h0);
    pm.set(P, 1'h1);
    mstop <= 1'h1;
    tick(2);
    mstop <= 1'h0;
    pm.set(FW, 1'h1);
    tick(2);
    pm.pulse(FS);
    chk("latch", 1'h1, latched);
    rdc("stat", `RPG_OFS_STAT, 32'h0000007C);
    mstop <= 1'h1;
    pm.set(FW, 1'h0);
    pm.pulse(FC);
    chk("latch", 1'h0, latched);
    chk("out", 1'h0, out_en);
    mstop <= 1'h0;
  endtask
  // ---------------------------------------------
  // Run
  // ---------------------------------------------
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    tmo();
  end
  initial begin
    {rst_n, awv, wv, bready, arv, rready, fault, inc, comm, mstop} = 10'h000;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    jog = 1'h0;
    tick(16);
    rst_n <= 1'h1;
    tick(1);
    t_regs();
    t_stop();
    t_res();
    t_loss();
    t_jog();
    tally_and_finish();
  end
endmodule
